// >>> iol_defines.svh
`ifndef IOL_DEFINES_SVH
`define IOL_DEFINES_SVH

// Register offsets (byte addresses)
`define IOL_OFS_LINE_PICK 8'h00
`define IOL_OFS_LINE_CFG 8'h04
`define IOL_OFS_SINGLE_STATE 8'h08
`define IOL_OFS_ALL_LO 8'h0C
`define IOL_OFS_ALL_HI 8'h10
`define IOL_OFS_USER_OUT 8'h14
`define IOL_OFS_MOD_CFG 8'h18

// Line map by state-word bit
`define IOL_NLINES 40
`define IOL_DIFFERENTIAL_STYLE_LO 0
`define IOL_ISO_IN_LO 4
`define IOL_ISO_OUT_LO 12
`define IOL_TTL_LO 16
`define IOL_EXT_LO 20

// Reset values
`define IOL_RST_FILTER 3'h1
`define IOL_RST_SRC 5'h00

// Source pick encoding
`define IOL_SRC_USER_LO 5'h01
`define IOL_SRC_STROBE_LO 5'h09
`define IOL_SRC_TRIG_LO 5'h0D
`define IOL_SRC_LAST 5'h10

// Timing
`define IOL_CLK_PERIOD_PS 4000
`define IOL_TC0_NS 50
`define IOL_TC1_NS 100
`define IOL_TC2_NS 200
`define IOL_TC3_NS 500
`define IOL_TC4_NS 1000
`define IOL_ISO_TC0_NS 500
`define IOL_ISO_TC1_NS 1000
`define IOL_ISO_TC2_NS 2000
`define IOL_ISO_TC3_NS 5000
`define IOL_ISO_TC4_NS 10000
`define IOL_CYC(ns) (((ns) * 1000 + `IOL_CLK_PERIOD_PS - 1) / `IOL_CLK_PERIOD_PS)

`endif

// >>> iol_pkg.sv
package iol_pkg;

   typedef enum logic [1:0] {
      IOL_DIR_IN,
      IOL_DIR_OUT,
      IOL_DIR_SINK,
      IOL_DIR_SOURCE
   } iol_dir_t;

   typedef enum logic [1:0] {
      IOL_STYLE_SINGLE,
      IOL_STYLE_DIFFERENTIAL_STYLE,
      IOL_STYLE_ISO
   } iol_style_t;

   typedef enum logic [2:0] {
      IOL_FLT_LOWEST,
      IOL_FLT_LOW,
      IOL_FLT_MEDIUM,
      IOL_FLT_HIGH,
      IOL_FLT_HIGHEST
   } iol_flt_t;

   typedef struct packed {
      logic [4:0] src;
      iol_style_t style;
      iol_flt_t flt;
      logic inv;
      iol_dir_t dir;
   } iol_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } iol_bus_t;

endpackage

// >>> iol_line_ctrl.sv
//
// Functional notes
// - Each line owns a fixed state-word bit
// - Fixed lines report their fixed electrical style
// - Fixed-direction lines refuse other direction settings
// - Single-ended lines: input, push-pull, sink, source
// - Single-ended lines power up as undriven inputs
// - Sink/source settings keep input path readable
// - Extension style selectable; even lines single-ended
// - Extension lines: input or push-pull output
// - Extension style/direction change only in configuration
// - One polarity flip inverts both paths
// - Five filter levels, default second-lowest
// - Filter constants per line type table
// - Clean input delayed exactly one time constant; the filter rounds up to whole clock cycles, after two sync stages
// - Line pick then source pick per output
// - Mux: user bits, strobes, low; triggers single-ended
// - State after inverter, or output before inverter
// - Single-line state follows line pick
// - Two all-lines words return every state: low word lines 0-31, high word lines 32-39
// - Power-on: no flip, level low, undriven, off
// - Sink drives low only; source drives high only
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "iol_defines.svh"

module iol_line_ctrl
   import iol_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire iol_bus_t bus,
   output logic [31:0] rdata,
   input wire logic [39:0] pin_in,
   output logic [39:0] pin_out,
   output logic [39:0] pin_oe,
   output logic [19:0] ext_differential_style,
   output logic [39:0] line_state,
   input wire logic [3:0] strobe_in,
   input wire logic [3:0] trigger_in
);

   // Reset asserts at once but leaves on the second edge
   logic rst_s1_reg;
   logic rst_n_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // Two stages before any logic reads a pin
   logic [39:0] pin_s1_reg;
   logic [39:0] pin_s2_reg;
   always_ff @(posedge clock or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_s1_reg <= 40'h00_0000_0000;
         pin_s2_reg <= 40'h00_0000_0000;
      end else begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Register state shared by all lines
   logic [5:0] pick_reg;
   logic [7:0] user_out_reg;
   logic mod_cfg_reg;
   logic [31:0] rdata_reg;
   logic [39:0] state_w;
   iol_cfg_t cfg_w [40];

   // Address decode, one compare per register
   wire hit_pick = bus.addr == `IOL_OFS_LINE_PICK;
   wire hit_cfg = bus.addr == `IOL_OFS_LINE_CFG;
   wire hit_single = bus.addr == `IOL_OFS_SINGLE_STATE;
   wire hit_lo = bus.addr == `IOL_OFS_ALL_LO;
   wire hit_hi = bus.addr == `IOL_OFS_ALL_HI;
   wire hit_user = bus.addr == `IOL_OFS_USER_OUT;
   wire hit_mod = bus.addr == `IOL_OFS_MOD_CFG;

   // Config word, one per line, written to the picked line:
   // [1:0] direction and drive, [2] polarity flip,
   // [5:3] filter level, [7:6] electrical style,
   // [12:8] output source: 0 steady low, 1-8 user bits,
   // 9-12 strobes, 13-16 camera triggers.
   // Refused fields keep their old value, so one bad field
   // never disturbs the rest of the word.
   wire cfg_wr = bus.wr && hit_cfg;
   wire iol_cfg_t wcfg = iol_cfg_t'(bus.wdata[12:0]);
   wire pick_ok = pick_reg < 6'(`IOL_NLINES);
   wire [5:0] pick_idx = pick_ok ? pick_reg : 6'h00;
   wire iol_cfg_t pick_cfg = cfg_w[pick_idx];
   wire single_bit = pick_ok & state_w[pick_idx];

   // Combined source vector, index is the source pick value
   // Index 0 is the steady-low source
   wire [16:0] src_vec = {trigger_in, strobe_in, user_out_reg, 1'b0};

   // Read mux; unmapped offsets read zero
   logic [31:0] rd_next;
   always_comb begin
      if (hit_pick) begin
         rd_next = {26'h000_0000, pick_reg};
      end else if (hit_cfg) begin
         rd_next = pick_ok ? {19'h0_0000, pick_cfg} : 32'h0000_0000;
      end else if (hit_single) begin
         rd_next = {31'h0000_0000, single_bit};
      end else if (hit_lo) begin
         rd_next = state_w[31:0];
      end else if (hit_hi) begin
         rd_next = {24'h00_0000, state_w[39:32]};
      end else if (hit_user) begin
         rd_next = {24'h00_0000, user_out_reg};
      end else if (hit_mod) begin
         rd_next = {31'h0000_0000, mod_cfg_reg};
      end else begin
         rd_next = 32'h0000_0000;
      end
   end

   // Line pick, also steers config and single-line reads
   always_ff @(posedge clock or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pick_reg <= 6'h00;
      end else if (bus.wr && hit_pick) begin
         pick_reg <= bus.wdata[5:0];
      end
   end

   // User output bits, selectable as output sources
   always_ff @(posedge clock or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         user_out_reg <= 8'h00;
      end else if (bus.wr && hit_user) begin
         user_out_reg <= bus.wdata[7:0];
      end
   end

   // Gate for extension style and direction changes
   always_ff @(posedge clock or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mod_cfg_reg <= 1'b0;
      end else if (bus.wr && hit_mod) begin
         mod_cfg_reg <= bus.wdata[0];
      end
   end

   // Read data stands one cycle, then returns to zero
   always_ff @(posedge clock or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= bus.rd ? rd_next : 32'h0000_0000;
      end
   end

   assign rdata = rdata_reg;

   // Filter thresholds per level, in clock cycles; rounded up so no level undercuts its constant
   localparam logic [11:0] TC_STD [5] = '{
      12'(`IOL_CYC(`IOL_TC0_NS)),
      12'(`IOL_CYC(`IOL_TC1_NS)),
      12'(`IOL_CYC(`IOL_TC2_NS)),
      12'(`IOL_CYC(`IOL_TC3_NS)),
      12'(`IOL_CYC(`IOL_TC4_NS))
   };
   localparam logic [11:0] TC_ISO [5] = '{
      12'(`IOL_CYC(`IOL_ISO_TC0_NS)),
      12'(`IOL_CYC(`IOL_ISO_TC1_NS)),
      12'(`IOL_CYC(`IOL_ISO_TC2_NS)),
      12'(`IOL_CYC(`IOL_ISO_TC3_NS)),
      12'(`IOL_CYC(`IOL_ISO_TC4_NS))
   };

   // One control block per line, its kind fixed by position
   genvar gi;
   generate
      for (gi = 0; gi < `IOL_NLINES; gi++) begin : g_line
         // Line kind is fixed by its bit position
         localparam bit IS_DIFFERENTIAL_STYLE = gi < `IOL_ISO_IN_LO;
         localparam bit IS_ISO_IN = gi >= `IOL_ISO_IN_LO && gi < `IOL_ISO_OUT_LO;
         localparam bit IS_ISO_OUT = gi >= `IOL_ISO_OUT_LO && gi < `IOL_TTL_LO;
         localparam bit IS_TTL = gi >= `IOL_TTL_LO && gi < `IOL_EXT_LO;
         localparam bit IS_EXT = gi >= `IOL_EXT_LO;
         // Odd-numbered extension lines sit on even offsets
         localparam bit EXT_DIFFERENTIAL_STYLE_OK = IS_EXT && ((gi - `IOL_EXT_LO) % 2 == 0);
         // Isolated outputs have no other direction
         localparam iol_dir_t DIR_RST = IS_ISO_OUT ? IOL_DIR_OUT : IOL_DIR_IN;
         localparam iol_style_t STY_FIX = (IS_ISO_IN || IS_ISO_OUT) ? IOL_STYLE_ISO :
            IS_DIFFERENTIAL_STYLE ? IOL_STYLE_DIFFERENTIAL_STYLE :
            IOL_STYLE_SINGLE;

         // Settings
         iol_dir_t dir_reg;
         logic inv_reg;
         iol_flt_t flt_reg;
         iol_style_t sty_reg;
         logic [4:0] src_reg;

         // Input path
         logic filt_reg;
         logic [11:0] cnt_reg;

         // Output path and state
         logic out_reg;
         logic oe_reg;
         logic state_reg;

         wire sel = cfg_wr && pick_reg == 6'(gi);
         wire ext_open = IS_EXT && mod_cfg_reg;

         // Directions each line kind will take
         wire dir_ok_ttl = 1'b1;
         wire dir_ok_iso_out = wcfg.dir == IOL_DIR_OUT;
         wire dir_ok_ext = ext_open && (wcfg.dir == IOL_DIR_IN || wcfg.dir == IOL_DIR_OUT);
         wire dir_ok_in = wcfg.dir == IOL_DIR_IN;
         wire dir_ok = IS_TTL ? dir_ok_ttl :
            IS_ISO_OUT ? dir_ok_iso_out :
            IS_EXT ? dir_ok_ext :
            dir_ok_in;

         wire sty_single = wcfg.style == IOL_STYLE_SINGLE;
         wire sty_differential_style = wcfg.style == IOL_STYLE_DIFFERENTIAL_STYLE && EXT_DIFFERENTIAL_STYLE_OK;
         wire sty_ok = ext_open && (sty_single || sty_differential_style);
         wire flt_ok = wcfg.flt <= IOL_FLT_HIGHEST;

         wire trig_src = wcfg.src >= `IOL_SRC_TRIG_LO;
         wire src_room = wcfg.src <= `IOL_SRC_LAST;
         wire src_dest = IS_TTL || !trig_src;
         wire src_ok = !(IS_DIFFERENTIAL_STYLE || IS_ISO_IN) && src_room && src_dest;

         // Direction: a refused value keeps the old setting
         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               dir_reg <= DIR_RST;
            end else if (sel && dir_ok) begin
               dir_reg <= wcfg.dir;
            end
         end

         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               inv_reg <= 1'b0;
            end else if (sel) begin
               inv_reg <= wcfg.inv;
            end
         end

         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               flt_reg <= iol_flt_t'(`IOL_RST_FILTER);
            end else if (sel && flt_ok) begin
               flt_reg <= wcfg.flt;
            end
         end

         // Style is only held by extension lines; others report a fixed one
         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               sty_reg <= IOL_STYLE_SINGLE;
            end else if (sel && sty_ok) begin
               sty_reg <= wcfg.style;
            end
         end

         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               src_reg <= `IOL_RST_SRC;
            end else if (sel && src_ok) begin
               src_reg <= wcfg.src;
            end
         end

         // Input path: inverter then glitch filter
         wire raw = pin_s2_reg[gi] ^ inv_reg;
         wire [11:0] thr = IS_ISO_IN ? TC_ISO[flt_reg] : TC_STD[flt_reg];
         // Flip lands on the Nth mismatching cycle; a return to the held level restarts the count
         wire done = cnt_reg + 12'h001 >= thr;

         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               filt_reg <= 1'b0;
               cnt_reg <= 12'h000;
            end else if (raw == filt_reg) begin
               cnt_reg <= 12'h000;
            end else if (done) begin
               filt_reg <= raw;
               cnt_reg <= 12'h000;
            end else begin
               cnt_reg <= cnt_reg + 12'h001;
            end
         end

         // Output path: source mux, inverter, driver mode
         wire logic_out = src_vec[src_reg];
         wire lvl = logic_out ^ inv_reg;
         logic drv_out;
         logic drv_oe;
         always_comb begin
            drv_out = lvl;
            drv_oe = 1'b0;
            if (IS_ISO_OUT) begin
               // Always enabled; a low level leaves the switch off
               drv_oe = 1'b1;
            end else if (IS_TTL) begin
               case (dir_reg)
                  IOL_DIR_OUT: drv_oe = 1'b1;
                  IOL_DIR_SINK: begin
                     drv_out = 1'b0;
                     drv_oe = !lvl;
                  end
                  IOL_DIR_SOURCE: begin
                     drv_out = 1'b1;
                     drv_oe = lvl;
                  end
                  default: drv_oe = 1'b0;
               endcase
            end else if (IS_EXT) begin
               case (dir_reg)
                  IOL_DIR_OUT: drv_oe = 1'b1;
                  default: drv_oe = 1'b0;
               endcase
            end
         end

         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               out_reg <= 1'b0;
               oe_reg <= 1'b0;
            end else begin
               out_reg <= drv_out;
               oe_reg <= drv_oe;
            end
         end

         // Wired lines read back the pin, not the driver
         always_ff @(posedge clock or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               state_reg <= 1'b0;
            end else begin
               state_reg <= state_w[gi];
            end
         end

         // Per-line outputs and the picked-line view
         assign pin_out[gi] = out_reg;
         assign pin_oe[gi] = oe_reg;
         // Reads use the unregistered state, matching line_state one cycle later
         assign state_w[gi] = IS_ISO_OUT ? logic_out : filt_reg;
         assign line_state[gi] = state_reg;
         // Fixed lines report their built-in style
         assign cfg_w[gi] = '{src: src_reg,
            style: IS_EXT ? sty_reg : STY_FIX,
            flt: flt_reg, inv: inv_reg, dir: dir_reg};
         if (IS_EXT) begin : g_ext
            // Bit 0 of the style marks differential, so the pin comes straight off a flop
            assign ext_differential_style[gi - `IOL_EXT_LO] = sty_reg[0];
         end
      end
   endgenerate

endmodule // iol_line_ctrl

`default_nettype wire

// >>> iol_line_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "iol_defines.svh"
module iol_line_ctrl_chk
   import iol_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire iol_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic [39:0] pin_in,
   input wire logic [39:0] pin_out,
   input wire logic [39:0] pin_oe,
   input wire logic [19:0] ext_differential_style,
   input wire logic [39:0] line_state,
   input wire logic [3:0] strobe_in,
   input wire logic [3:0] trigger_in
);
   logic mod_en_reg;
   wire mod_wr = bus.wr && bus.addr == `IOL_OFS_MOD_CFG;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) mod_en_reg <= 1'b0;
      else if (mod_wr) mod_en_reg <= bus.wdata[0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_rd_idle; (!bus.rd || bus.addr > 8'h18) |=> rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_all_lo; bus.rd && bus.addr == `IOL_OFS_ALL_LO |=> rdata == line_state[31:0]; endproperty
   a_all_lo: assert property (p_all_lo) else $error("low state word differs");
   property p_all_hi; bus.rd && bus.addr == `IOL_OFS_ALL_HI |=> rdata == {24'h0, line_state[39:32]}; endproperty
   a_all_hi: assert property (p_all_hi) else $error("high state word differs");
   property p_single; bus.rd && bus.addr == `IOL_OFS_SINGLE_STATE |=> rdata[31:1] == 31'h0; endproperty
   a_single: assert property (p_single) else $error("single state wider than one bit");
   property p_in_undriven; pin_oe[11:0] == 12'h000; endproperty
   a_in_undriven: assert property (p_in_undriven) else $error("input-only line driven");
   property p_power_on; $rose(nrst) |-> (pin_oe[19:16] == 4'h0 && pin_out[15:12] == 4'h0) [*3]; endproperty
   a_power_on: assert property (p_power_on) else $error("lines driven after power-on");
   property p_even_single; (ext_differential_style & 20'hAAAAA) == 20'h00000; endproperty
   a_even_single: assert property (p_even_single) else $error("even extension line differential");
   property p_cfg_locked; !mod_en_reg && bus.wr |=> $stable(ext_differential_style); endproperty
   a_cfg_locked: assert property (p_cfg_locked) else $error("style changed outside configuration");
   c_all_rd: cover property (bus.rd && bus.addr == `IOL_OFS_ALL_LO);
   c_se_drive: cover property ($rose(pin_oe[16]));
   c_ext_differential_style: cover property ($rose(ext_differential_style[0]));
endmodule // iol_line_ctrl_chk
bind iol_line_ctrl iol_line_ctrl_chk u_chk (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ext_differential_style(ext_differential_style), .line_state(line_state),
   .strobe_in(strobe_in), .trigger_in(trigger_in));
`default_nettype wire

// >>> iol_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module iol_pin_model (
   input wire logic [39:0] pin_out,
   input wire logic [39:0] pin_oe,
   input wire logic [39:0] ext_lvl,
   output logic [39:0] pin_in
);
   // Undriven pins follow the external source, so wired-AND readback is visible
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // iol_pin_model
`default_nettype wire

// >>> iol_line_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "iol_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module iol_line_ctrl_test
   import iol_pkg::*;
;
   typedef struct packed { logic [7:0] line; logic [11:0] wval; logic [11:0] rval; } iol_row_t;
   logic clock, nrst, lvl, eo;
   iol_bus_t bus;
   logic [31:0] rdata, d;
   logic [39:0] pin_in, pin_out, pin_oe, line_state, ext_lvl;
   logic [19:0] ext_differential_style;
   logic [3:0] strobe_in, trigger_in;
   int errors, cmp_count, n;
   iol_row_t rows [9] = '{'{8'h00, 12'h009, 12'h048}, '{8'h04, 12'h00A, 12'h088}, '{8'h0C, 12'h008, 12'h089},
      '{8'h10, 12'h008, 12'h008}, '{8'h10, 12'h009, 12'h009}, '{8'h10, 12'h00A, 12'h00A},
      '{8'h10, 12'h00B, 12'h00B}, '{8'h10, 12'h02B, 12'h00B}, '{8'h14, 12'h049, 12'h008}};
   iol_line_ctrl DUT (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .ext_differential_style(ext_differential_style), .line_state(line_state), .strobe_in(strobe_in), .trigger_in(trigger_in));
   iol_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic tally_and_finish;
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 d = rdata;
      @(posedge clock);
   endtask
   task automatic cfg(input logic [7:0] l, input logic [11:0] v);
      wr(`IOL_OFS_LINE_PICK, {24'h0, l});
      wr(`IOL_OFS_LINE_CFG, {20'h0, v});
   endtask
   // Edges from pin change to visible state; bounded so a dead filter ends the run
   task automatic rise(input int l, input int lo);
      n = 0;
      ext_lvl[l] <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         #1;
      end while (line_state[l] !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         errors++;
         tally_and_finish;
      end
      `CHK(n >= lo && n <= lo + 2, 1'b1)
      @(posedge clock);
   endtask
   initial begin
      nrst = 1'b0;
      bus = '0;
      ext_lvl = '0;
      strobe_in = 4'h0;
      trigger_in = 4'h0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK(pin_oe[19:16], 4'h0)
      foreach (rows[i]) begin
         cfg(rows[i].line, rows[i].wval);
         rd(`IOL_OFS_LINE_CFG);
         `CHK(d[11:0], rows[i].rval)
      end
      cfg(8'h10, 12'h000);
      rise(16, 15);
      cfg(8'h04, 12'h000);
      rise(4, 127);
      ext_lvl[0] <= 1'b1;
      repeat (20) @(posedge clock);
      ext_lvl[0] <= 1'b0;
      repeat (40) @(posedge clock);
      `CHK(line_state[0], 1'b0)
      for (int m = 4; m < 16; m++) begin
         lvl = m[0] ^ m[1];
         eo = m[3:2] == 2'h1 || (m[3] && m[2] == lvl);
         cfg(8'h10, {4'h1, 5'h00, m[1], m[3:2]});
         wr(`IOL_OFS_USER_OUT, {31'h0, m[0]});
         repeat (2) @(posedge clock);
         `CHK(pin_oe[16], eo)
         if (eo) `CHK(pin_out[16], lvl)
      end
      repeat (20) @(posedge clock);
      `CHK(line_state[16], 1'b0)
      for (int s = 9; s <= 13; s += 4) begin
         cfg(8'h10, {s[3:0], 8'h01});
         {strobe_in, trigger_in} <= (s == 9) ? 8'h10 : 8'h01;
         repeat (3) @(posedge clock);
         `CHK(pin_out[16], 1'b1)
         {strobe_in, trigger_in} <= 8'h00;
         repeat (3) @(posedge clock);
         `CHK(pin_out[16], 1'b0)
      end
      cfg(8'h0C, 12'h10D);
      wr(`IOL_OFS_USER_OUT, 32'h1);
      repeat (4) @(posedge clock);
      `CHK({line_state[12], pin_out[12]}, 2'b10)
      rd(`IOL_OFS_SINGLE_STATE);
      `CHK(d, 32'h1)
      wr(`IOL_OFS_LINE_CFG, 32'hD0D);
      rd(`IOL_OFS_LINE_CFG);
      `CHK(d[11:8], 4'h1)
      rd(`IOL_OFS_ALL_LO);
      `CHK(d[12], 1'b1)
      wr(`IOL_OFS_MOD_CFG, 32'h1);
      cfg(8'h14, 12'h049);
      cfg(8'h15, 12'h048);
      `CHK(ext_differential_style[1:0], 2'b01)
      `CHK(pin_oe[20], 1'b1)
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK({pin_oe[20], pin_oe[16], ext_differential_style[0]}, 3'b000)
      rd(`IOL_OFS_LINE_CFG);
      `CHK(d[11:0], 12'h048)
      rd(8'h1C);
      `CHK(d, 32'h0)
      tally_and_finish;
   end
endmodule // iol_line_ctrl_test
`default_nettype wire
